// ---- micro_port_pkg.sv ----
package micro_port_pkg;
	localparam int AD_W         = 8;
	localparam int DMA_W        = 16;
	localparam int CNT_W        = 8;
	localparam int CLK_MHZ      = 200;
	// Least width of a DMA strobe and of a processor strobe
	localparam int DMA_STROBE_NS = 50;
	localparam int DMA_STROBE_CYC =
		(DMA_STROBE_NS * CLK_MHZ + 999) / 1000;
	localparam int CPU_STROBE_NS = 40;
	localparam int CPU_STROBE_CYC =
		(CPU_STROBE_NS * CLK_MHZ + 999) / 1000;
	// Least width of the address latch pulse
	localparam int LATCH_NS     = 20;
	localparam int LATCH_CYC    = (LATCH_NS * CLK_MHZ + 999) / 1000;
	localparam logic [7:0]  RESET_ADDR = 8'h00;
	localparam logic [7:0]  RESET_BYTE = 8'h00;
	localparam logic [15:0] RESET_WORD = 16'h0000;

	typedef enum logic [1:0] {
		DMA_IDLE   = 2'b00,
		DMA_ACK    = 2'b01,
		DMA_STROBE = 2'b11,
		DMA_DONE   = 2'b10
	} dmaState_t;

	typedef enum logic [2:0] {
		CPU_IDLE   = 3'b000,
		CPU_LATCH  = 3'b001,
		CPU_SETUP  = 3'b011,
		CPU_STROBE = 3'b010,
		CPU_HOLD   = 3'b110
	} cpuState_t;

	// Odd parity: the bit makes the count of ones in byte and bit odd
	function automatic logic oddParity(input logic [7:0] b);
		return ~(^b);
	endfunction
endpackage

// ---- micro_port_if.sv ----
`timescale 1ns/1ps
interface micro_port_if;
	logic [7:0]  hostAdOut;
	logic        hostAdOe;
	logic [7:0]  devAdOut;
	logic        devAdOe;
	logic [7:0]  adLine;
	logic        ale;
	logic        readStrobeN;
	logic        writeStrobeN;
	logic        diskSideSelectN;
	logic        scsiSideSelectN;
	logic        readyOut;
	logic        readyOe;
	logic        readyLine;
	logic        diskIrqA;
	logic        diskIrqB;
	logic        scsiIrq;
	logic [1:0]  internalOut;
	logic        internalOe;
	logic        externalChanRequest;
	logic        externalChanAck;
	logic        dmaStrobeOe;
	logic        dmaWriteStrobeN;
	logic        dmaReadStrobeN;
	logic        dmaWriteLine;
	logic        dmaReadLine;
	logic [15:0] devBusOut;
	logic [1:0]  devParOut;
	logic        devBusOe;
	logic [15:0] slaveBusOut;
	logic [1:0]  slaveParOut;
	logic        slaveBusOe;
	logic [15:0] hostDmaBus;
	logic [1:0]  hostBusParity;

	// Undriven lines settle low, except pulled-up ready and strobes
	assign adLine = devAdOe ? devAdOut : (hostAdOe ? hostAdOut : 8'h00);
	assign readyLine = ~(readyOe & ~readyOut);
	assign dmaWriteLine = dmaStrobeOe ? dmaWriteStrobeN : 1'b1;
	assign dmaReadLine = dmaStrobeOe ? dmaReadStrobeN : 1'b1;
	assign hostDmaBus = devBusOe ? devBusOut
		: (slaveBusOe ? slaveBusOut : 16'h0000);
	assign hostBusParity = devBusOe ? devParOut
		: (slaveBusOe ? slaveParOut : 2'h0);

	modport device (
		input  adLine, ale, readStrobeN, writeStrobeN,
		input  diskSideSelectN, scsiSideSelectN,
		input  externalChanRequest, dmaWriteLine, dmaReadLine,
		input  hostDmaBus, hostBusParity,
		output devAdOut, devAdOe, readyOut, readyOe,
		output diskIrqA, diskIrqB, scsiIrq, internalOut, internalOe,
		output externalChanAck, dmaStrobeOe, dmaWriteStrobeN,
		output dmaReadStrobeN, devBusOut, devParOut, devBusOe
	);
	modport host (
		input  adLine, readyLine, diskIrqA, diskIrqB, scsiIrq,
		input  externalChanAck, dmaWriteLine, dmaReadLine,
		input  hostDmaBus, hostBusParity,
		output hostAdOut, hostAdOe, ale, readStrobeN, writeStrobeN,
		output diskSideSelectN, scsiSideSelectN, externalChanRequest,
		output slaveBusOut, slaveParOut, slaveBusOe
	);
endinterface

// ---- micro_port_host.sv ----
`timescale 1ns/1ps
module micro_port_host #(
	parameter int STROBE_CYC = micro_port_pkg::CPU_STROBE_CYC,
	parameter int LATCH_CYC  = micro_port_pkg::LATCH_CYC
) (
	micro_port_if.host       pins,
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        cmdValid,
	output logic             cmdReady,
	input  wire logic        cmdWrite,
	input  wire logic        cmdScsi,
	input  wire logic [7:0]  cmdAddr,
	input  wire logic [7:0]  cmdData,
	output logic             rspValid,
	output logic [7:0]       rspData,
	output logic [2:0]       irqSeen,
	input  wire logic        ackActiveLow,
	input  wire logic        slaveStart,
	input  wire logic [15:0] slaveTxData,
	output logic             slaveBusy,
	output logic [15:0]      slaveRxData,
	output logic             slaveRxValid,
	output logic             slaveParityError
);
	if (STROBE_CYC < 2 || STROBE_CYC > 255 || LATCH_CYC < 1
		|| LATCH_CYC > 255) begin : badParam
		$error("micro_port_host: strobe or latch count out of range");
	end

	typedef struct packed {
		micro_port_pkg::cpuState_t state;
		logic [7:0]  cnt;
		logic [7:0]  addr;
		logic [7:0]  data;
		logic        write;
		logic        scsi;
		logic        rspValid;
		logic [7:0]  rspData;
		logic [2:0]  irq;
		logic        pending;
		logic [15:0] txData;
		logic        wrSeen;
		logic [15:0] rxData;
		logic        rxValid;
		logic        parErr;
	} host_t;

	host_t cur;
	host_t next_cur;
	logic  acked;
	logic  selActive;

	assign acked = pins.externalChanAck ^ ackActiveLow;
	assign selActive = cur.state == micro_port_pkg::CPU_SETUP
		|| cur.state == micro_port_pkg::CPU_STROBE
		|| cur.state == micro_port_pkg::CPU_HOLD;

	always_comb begin
		next_cur = cur;
		next_cur.rspValid = 1'b0;
		next_cur.rxValid = 1'b0;
		next_cur.irq = {pins.scsiIrq, pins.diskIrqB, pins.diskIrqA};
		case (cur.state)
			micro_port_pkg::CPU_IDLE: begin
				if (cmdValid) begin
					next_cur.state = micro_port_pkg::CPU_LATCH;
					next_cur.addr = cmdAddr;
					next_cur.data = cmdData;
					next_cur.write = cmdWrite;
					next_cur.scsi = cmdScsi;
					next_cur.cnt = 8'(LATCH_CYC - 1);
				end
			end
			micro_port_pkg::CPU_LATCH: begin
				if (cur.cnt == 8'h00) begin
					next_cur.state = micro_port_pkg::CPU_SETUP;
				end else begin
					next_cur.cnt = cur.cnt - 8'h01;
				end
			end
			micro_port_pkg::CPU_SETUP: begin
				next_cur.state = micro_port_pkg::CPU_STROBE;
				next_cur.cnt = 8'(STROBE_CYC - 1);
			end
			micro_port_pkg::CPU_STROBE: begin
				if (cur.cnt != 8'h00) begin
					next_cur.cnt = cur.cnt - 8'h01;
				end else if (pins.readyLine) begin
					next_cur.state = micro_port_pkg::CPU_HOLD;
					if (!cur.write) begin
						next_cur.rspData = pins.adLine;
					end
				end
			end
			micro_port_pkg::CPU_HOLD: begin
				next_cur.state = micro_port_pkg::CPU_IDLE;
				next_cur.rspValid = 1'b1;
			end
			default: begin
				next_cur.state = micro_port_pkg::CPU_IDLE;
			end
		endcase
		// External slave: one transfer per start, request drops at strobe
		if (slaveStart && !cur.pending) begin
			next_cur.pending = 1'b1;
			next_cur.txData = slaveTxData;
		end
		if (acked && (!pins.dmaReadLine || !pins.dmaWriteLine)) begin
			next_cur.pending = 1'b0;
		end
		if (acked && !pins.dmaWriteLine) begin
			next_cur.wrSeen = 1'b1;
			next_cur.rxData = pins.hostDmaBus;
			next_cur.parErr =
				pins.hostBusParity[0] !=
				micro_port_pkg::oddParity(pins.hostDmaBus[7:0])
				|| pins.hostBusParity[1] !=
				micro_port_pkg::oddParity(pins.hostDmaBus[15:8]);
		end else if (cur.wrSeen) begin
			next_cur.wrSeen = 1'b0;
			next_cur.rxValid = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign cmdReady = cur.state == micro_port_pkg::CPU_IDLE;
	assign pins.ale = cur.state == micro_port_pkg::CPU_LATCH;
	assign pins.hostAdOut = pins.ale ? cur.addr : cur.data;
	assign pins.hostAdOe = pins.ale || (selActive && cur.write);
	assign pins.readStrobeN =
		!(cur.state == micro_port_pkg::CPU_STROBE && !cur.write);
	assign pins.writeStrobeN =
		!(cur.state == micro_port_pkg::CPU_STROBE && cur.write);
	assign pins.diskSideSelectN = !(selActive && !cur.scsi);
	assign pins.scsiSideSelectN = !(selActive && cur.scsi);
	assign pins.externalChanRequest = cur.pending;
	assign pins.slaveBusOut = cur.txData;
	assign pins.slaveParOut = {micro_port_pkg::oddParity(cur.txData[15:8]),
		micro_port_pkg::oddParity(cur.txData[7:0])};
	assign pins.slaveBusOe = acked && !pins.dmaReadLine;
	assign rspValid = cur.rspValid;
	assign rspData = cur.rspData;
	assign irqSeen = cur.irq;
	assign slaveBusy = cur.pending;
	assign slaveRxData = cur.rxData;
	assign slaveRxValid = cur.rxValid;
	assign slaveParityError = cur.parErr;
endmodule

// ---- micro_port_device.sv ----
`timescale 1ns/1ps
module micro_port_device #(
	parameter int STROBE_CYC = micro_port_pkg::DMA_STROBE_CYC
) (
	micro_port_if.device     pins,
	input  wire logic        sys_clk,
	input  wire logic        rst,
	output logic [7:0]       regAddr,
	output logic [7:0]       regWriteData,
	output logic             diskWrite,
	output logic             scsiWrite,
	output logic             diskRead,
	output logic             scsiRead,
	input  wire logic [7:0]  diskReadData,
	input  wire logic [7:0]  scsiReadData,
	input  wire logic        accessStall,
	input  wire logic        diskEventA,
	input  wire logic        diskEventB,
	input  wire logic        scsiEvent,
	input  wire logic        testMode,
	input  wire logic        internalReqTest,
	input  wire logic        internalAckTest,
	input  wire logic        ackActiveLow,
	input  wire logic        dmaToSlave,
	input  wire logic [15:0] dmaTxData,
	output logic             dmaBusy,
	output logic [15:0]      dmaRxData,
	output logic             dmaRxValid,
	output logic             dmaParityError
);
	if (STROBE_CYC < 1 || STROBE_CYC > 255) begin : badParam
		$error("micro_port_device: STROBE_CYC out of range");
	end

	typedef struct packed {
		logic        aleSeen;
		logic [7:0]  aleShadow;
		logic [7:0]  addr;
		logic [7:0]  rdData;
		logic        readSeen;
		logic        wrActive;
		logic        wrDisk;
		logic [7:0]  wrData;
		logic        diskWr;
		logic        scsiWr;
		logic [2:0]  irq;
		logic [1:0]  internal;
		micro_port_pkg::dmaState_t dmaState;
		logic [7:0]  cnt;
		logic        toSlave;
		logic [15:0] txData;
		logic [15:0] rxData;
		logic        rxValid;
		logic        parErr;
	} dev_t;

	dev_t cur;
	dev_t next_cur;
	logic diskSel;
	logic scsiSel;
	logic readAct;
	logic writeAct;
	logic servicing;
	logic strobing;
	logic ackActive;

	// Disk select wins if both are low, so one space answers
	assign diskSel = !pins.diskSideSelectN;
	assign scsiSel = !pins.scsiSideSelectN && !diskSel;
	assign readAct = !pins.readStrobeN && (diskSel || scsiSel);
	assign writeAct = !pins.writeStrobeN && (diskSel || scsiSel);
	assign servicing = cur.dmaState != micro_port_pkg::DMA_IDLE;
	assign strobing = cur.dmaState == micro_port_pkg::DMA_STROBE;
	assign ackActive = cur.dmaState == micro_port_pkg::DMA_ACK || strobing;

	always_comb begin
		next_cur = cur;
		next_cur.diskWr = 1'b0;
		next_cur.scsiWr = 1'b0;
		next_cur.rxValid = 1'b0;
		// Shadow follows the bus while latch is high, commits on fall
		next_cur.aleSeen = pins.ale;
		if (pins.ale) begin
			next_cur.aleShadow = pins.adLine;
		end
		if (cur.aleSeen && !pins.ale) begin
			next_cur.addr = cur.aleShadow;
		end
		next_cur.rdData = diskSel ? diskReadData : scsiReadData;
		next_cur.readSeen = readAct;
		// Write commits as the strobe ends, with data of its last cycle
		if (writeAct) begin
			next_cur.wrActive = 1'b1;
			next_cur.wrDisk = diskSel;
			next_cur.wrData = pins.adLine;
		end else if (cur.wrActive) begin
			next_cur.wrActive = 1'b0;
			next_cur.diskWr = cur.wrDisk;
			next_cur.scsiWr = !cur.wrDisk;
		end
		next_cur.irq = {scsiEvent, diskEventB, diskEventA};
		next_cur.internal = {internalAckTest, internalReqTest};
		case (cur.dmaState)
			micro_port_pkg::DMA_IDLE: begin
				next_cur.txData = dmaTxData;
				if (pins.externalChanRequest && !testMode) begin
					next_cur.dmaState = micro_port_pkg::DMA_ACK;
					next_cur.toSlave = dmaToSlave;
				end
			end
			micro_port_pkg::DMA_ACK: begin
				next_cur.dmaState = micro_port_pkg::DMA_STROBE;
				next_cur.cnt = 8'(STROBE_CYC - 1);
			end
			micro_port_pkg::DMA_STROBE: begin
				if (cur.cnt != 8'h00) begin
					next_cur.cnt = cur.cnt - 8'h01;
				end else begin
					next_cur.dmaState = micro_port_pkg::DMA_DONE;
					if (!cur.toSlave) begin
						next_cur.rxData = pins.hostDmaBus;
						next_cur.rxValid = 1'b1;
						next_cur.parErr =
							pins.hostBusParity[0] != micro_port_pkg::
							oddParity(pins.hostDmaBus[7:0])
							|| pins.hostBusParity[1] != micro_port_pkg::
							oddParity(pins.hostDmaBus[15:8]);
					end
				end
			end
			micro_port_pkg::DMA_DONE: begin
				// Request must drop before a new transfer, no double service
				if (!pins.externalChanRequest) begin
					next_cur.dmaState = micro_port_pkg::DMA_IDLE;
				end
			end
			default: begin
				next_cur.dmaState = micro_port_pkg::DMA_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign pins.devAdOut = cur.rdData;
	assign pins.devAdOe = readAct;
	// First read cycle waits while the read data flop fills
	assign pins.readyOut = 1'b0;
	assign pins.readyOe = (readAct || writeAct)
		&& (accessStall || (readAct && !cur.readSeen));
	assign pins.diskIrqA = cur.irq[0];
	assign pins.diskIrqB = cur.irq[1];
	assign pins.scsiIrq = cur.irq[2];
	assign pins.internalOut = cur.internal;
	assign pins.internalOe = testMode;
	assign pins.externalChanAck = ackActive ^ ackActiveLow;
	assign pins.dmaStrobeOe = testMode || servicing;
	assign pins.dmaWriteStrobeN = !(strobing && cur.toSlave);
	assign pins.dmaReadStrobeN = !(strobing && !cur.toSlave);
	assign pins.devBusOut = cur.txData;
	assign pins.devParOut =
		{micro_port_pkg::oddParity(cur.txData[15:8]),
		micro_port_pkg::oddParity(cur.txData[7:0])};
	// Reads from the slave leave the bus to it, avoiding a fight
	assign pins.devBusOe = testMode || (servicing && cur.toSlave);
	assign regAddr = cur.addr;
	assign regWriteData = cur.wrData;
	assign diskWrite = cur.diskWr;
	assign scsiWrite = cur.scsiWr;
	assign diskRead = readAct && diskSel;
	assign scsiRead = readAct && scsiSel;
	assign dmaBusy = servicing;
	assign dmaRxData = cur.rxData;
	assign dmaRxValid = cur.rxValid;
	assign dmaParityError = cur.parErr;
endmodule

// ---- micro_port_checker.sv ----
`timescale 1ns/1ps
module micro_port_checker (
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic        hostAdOe,
	input wire logic        devAdOe,
	input wire logic        readStrobeN,
	input wire logic        writeStrobeN,
	input wire logic        diskSideSelectN,
	input wire logic        scsiSideSelectN,
	input wire logic        readyLine,
	input wire logic        internalOe,
	input wire logic        dmaStrobeOe,
	input wire logic        dmaWriteLine,
	input wire logic        dmaReadLine,
	input wire logic        externalChanRequest,
	input wire logic        devBusOe,
	input wire logic [15:0] hostDmaBus,
	input wire logic [1:0]  hostBusParity
);
	default clocking dc @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	chk_ad_single: assert property (
		!(devAdOe && hostAdOe))
		else $error("AD bus driven from both ends");
	// One cycle of slack allows a registered output enable
	chk_read_drive: assert property (
		devAdOe |-> (!readStrobeN || $past(!readStrobeN))
		&& !(diskSideSelectN && scsiSideSelectN))
		else $error("AD driven outside a selected read");
	chk_write_quiet: assert property (
		!writeStrobeN |-> !devAdOe)
		else $error("AD driven during a write");
	chk_strobe_wait: assert property (
		($rose(readStrobeN) || $rose(writeStrobeN)) |-> $past(readyLine))
		else $error("Strobe ended while ready low");
	chk_read_ready: assert property (
		$fell(readStrobeN) |-> ##[0:2] !readyLine)
		else $error("Read not stretched by ready");
	chk_test_drive: assert property (
		internalOe |-> (dmaStrobeOe || $past(dmaStrobeOe)) && devBusOe)
		else $error("Test mode pins not all driven");
	chk_strobe_cause: assert property (
		($fell(dmaWriteLine) || $fell(dmaReadLine)) |->
		$past(externalChanRequest) || $past(externalChanRequest, 2)
		|| $past(externalChanRequest, 3))
		else $error("DMA strobe without a request");
	chk_strobe_width: assert property (
		$fell(dmaWriteLine) || $fell(dmaReadLine) |->
		(!dmaWriteLine || !dmaReadLine) [*4])
		else $error("DMA strobe too short");
	chk_parity_odd: assert property (
		devBusOe |-> hostBusParity
		== {~^hostDmaBus[15:8], ~^hostDmaBus[7:0]})
		else $error("Bus parity not odd");
	chk_bus_service: assert property (
		devBusOe |-> dmaStrobeOe || $past(dmaStrobeOe))
		else $error("DMA bus driven outside service");
endmodule

// ---- micro_port_and_dma_pins_bench.sv ----
`timescale 1ns/1ps
module micro_port_and_dma_pins_bench;
	logic        sys_clk, rst, cmdValid, cmdReady, cmdWrite, cmdScsi;
	logic [7:0]  cmdAddr, cmdData, rspData, regAddr, regWriteData, a, d;
	logic [7:0]  diskReadData, scsiReadData;
	logic        rspValid, ackActiveLow, slaveStart, slaveBusy, sc;
	logic        slaveRxValid, slaveParityError, diskWrite, scsiWrite;
	logic        diskRead, scsiRead, accessStall, diskEventA, diskEventB;
	logic        scsiEvent, testMode, internalReqTest, internalAckTest;
	logic        dmaToSlave, dmaBusy, dmaRxValid, dmaParityError;
	logic [2:0]  irqSeen;
	logic [15:0] slaveTxData, slaveRxData, dmaTxData, dmaRxData, w;
	logic        sawDiskRead, sawScsiRead;
	int          n_mismatch, comparisons, nDisk, nScsi, k, base;

	micro_port_if pins ();
	micro_port_host #(.STROBE_CYC(2), .LATCH_CYC(1)) u_micro_port_host (
		.pins(pins), .sys_clk, .rst, .cmdValid, .cmdReady, .cmdWrite,
		.cmdScsi, .cmdAddr, .cmdData, .rspValid, .rspData, .irqSeen,
		.ackActiveLow, .slaveStart, .slaveTxData, .slaveBusy,
		.slaveRxData, .slaveRxValid, .slaveParityError);
	micro_port_device #(.STROBE_CYC(4)) u_micro_port_device (
		.pins(pins), .sys_clk, .rst, .regAddr, .regWriteData, .diskWrite,
		.scsiWrite, .diskRead, .scsiRead, .diskReadData, .scsiReadData,
		.accessStall, .diskEventA, .diskEventB, .scsiEvent, .testMode,
		.internalReqTest, .internalAckTest, .ackActiveLow, .dmaToSlave,
		.dmaTxData, .dmaBusy, .dmaRxData, .dmaRxValid, .dmaParityError);
	micro_port_checker u_micro_port_checker (
		.sys_clk, .rst, .hostAdOe(pins.hostAdOe), .devAdOe(pins.devAdOe),
		.readStrobeN(pins.readStrobeN), .writeStrobeN(pins.writeStrobeN),
		.diskSideSelectN(pins.diskSideSelectN),
		.scsiSideSelectN(pins.scsiSideSelectN),
		.readyLine(pins.readyLine), .internalOe(pins.internalOe),
		.dmaStrobeOe(pins.dmaStrobeOe), .dmaWriteLine(pins.dmaWriteLine),
		.dmaReadLine(pins.dmaReadLine), .devBusOe(pins.devBusOe),
		.externalChanRequest(pins.externalChanRequest),
		.hostDmaBus(pins.hostDmaBus), .hostBusParity(pins.hostBusParity));

	always #2.5 sys_clk = ~sys_clk;

	task automatic check(input logic [15:0] seen, exp, input string m);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t %s: %h expected %h", $time, m, seen, exp);
		end
	endtask

	task automatic conclude();
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	// Odd parity per byte, high byte in bit 1
	function automatic logic [1:0] expPar(input logic [15:0] v);
		return {~^v[15:8], ~^v[7:0]};
	endfunction

	function automatic logic ev(input int s);
		case (s)
			0: return rspValid;
			1: return dmaRxValid;
			2: return slaveRxValid;
			3: return !(slaveBusy || dmaBusy);
			default: return cmdReady;
		endcase
	endfunction

	task automatic waitEv(input int s);
		int i;
		for (i = 0; i < 300 && ev(s) !== 1'h1; i++) tick(1);
		if (i == 300) begin
			n_mismatch++;
			conclude();
		end
	endtask

	task automatic access(input logic wr, s, input logic [7:0] ad, dt);
		waitEv(4);
		cmdValid = 1'h1;
		cmdWrite = wr;
		cmdScsi = s;
		cmdAddr = ad;
		cmdData = dt;
		tick(1);
		cmdValid = 1'h0;
		waitEv(0);
	endtask

	// Acknowledge must read active for every cycle a strobe is low
	// Sampled mid-cycle, where registered pins have settled
	always @(negedge sys_clk) begin
		if (!rst && !testMode && !(pins.dmaWriteLine && pins.dmaReadLine))
			check(16'(pins.externalChanAck), 16'(!ackActiveLow),
				"ack");
		if (diskWrite) nDisk++;
		if (scsiWrite) nScsi++;
		if (diskRead) sawDiskRead = 1'h1;
		if (scsiRead) sawScsiRead = 1'h1;
	end

	initial begin
		{sys_clk, cmdValid, cmdWrite, cmdScsi, cmdAddr, cmdData} = '0;
		{ackActiveLow, slaveStart, slaveTxData, diskReadData} = '0;
		{scsiReadData, accessStall, diskEventA, diskEventB} = '0;
		{scsiEvent, testMode, internalReqTest, internalAckTest} = '0;
		{dmaToSlave, dmaTxData, n_mismatch, comparisons} = '0;
		{nDisk, nScsi, sawDiskRead, sawScsiRead} = '0;
		rst = 1'h1;
		void'($urandom(84));
		tick(5);
		rst = 1'h0;
		for (k = 0; k < 8; k++) begin
			a = (k == 0) ? 8'hFF : ((k == 1) ? 8'h00 : 8'($urandom));
			d = 8'($urandom);
			sc = k[0];
			base = nScsi;
			access(1'h1, sc, a, d);
			tick(3);
			check(16'(regAddr), 16'(a), "write addr");
			check(16'(regWriteData), 16'(d), "write data");
			check(16'(nScsi - base), 16'(sc), "scsi writes");
			check(16'(nDisk + nScsi), 16'(k + 1), "writes");
		end
		// Odd passes hold ready low so the strobe must stretch
		for (k = 0; k < 6; k++) begin
			a = 8'($urandom);
			sc = k[1];
			diskReadData = 8'($urandom);
			scsiReadData = ~diskReadData;
			base = nDisk + nScsi;
			accessStall = k[0];
			{sawDiskRead, sawScsiRead} = 2'h0;
			fork
				access(1'h0, sc, a, 8'h00);
				begin
					tick(12);
					accessStall = 1'h0;
				end
			join
			check(16'(rspData), 16'(sc ? scsiReadData : diskReadData),
				"read data");
			check(16'(regAddr), 16'(a), "read addr");
			check(16'(nDisk + nScsi - base), 16'h0000,
				"read wrote");
			check(16'({sawScsiRead, sawDiskRead}), 16'({sc, !sc}),
				"read side");
		end
		for (k = 0; k < 8; k++) begin
			{scsiEvent, diskEventB, diskEventA} = 3'(k);
			tick(2);
			check(16'({pins.scsiIrq, pins.diskIrqB, pins.diskIrqA}), 16'(k),
				"irq");
			check(16'(irqSeen), 16'(k), "irq seen");
		end
		for (k = 0; k < 6; k++) begin
			ackActiveLow = k[1];
			dmaToSlave = k[0];
			w = (k < 2) ? {16{k[0]}} : 16'($urandom);
			dmaTxData = dmaToSlave ? w : ~w;
			slaveTxData = dmaToSlave ? ~w : w;
			tick(2);
			check(16'(pins.externalChanAck), 16'(ackActiveLow),
				"ack idle");
			check(16'({pins.dmaWriteLine, pins.dmaReadLine, pins.dmaStrobeOe}),
				16'h0006, "idle strobes");
			slaveStart = 1'h1;
			tick(1);
			slaveStart = 1'h0;
			if (dmaToSlave) begin
				waitEv(2);
				check(slaveRxData, w, "to slave");
				check(16'(slaveParityError), 16'h0000,
					"slave parity");
			end else begin
				waitEv(1);
				check(dmaRxData, w, "from slave");
				check(16'(dmaParityError), 16'h0000,
					"dev parity");
			end
			waitEv(3);
		end
		for (k = 1; k < 3; k++) begin
			{internalAckTest, internalReqTest} = 2'(k);
			dmaTxData = 16'($urandom);
			testMode = 1'h1;
			tick(3);
			check(16'({pins.internalOe, pins.internalOut}), 16'h0004 + 16'(k),
				"test pins");
			check(pins.hostDmaBus, dmaTxData, "test bus");
			check(16'(pins.hostBusParity), 16'(expPar(dmaTxData)),
				"parity");
			testMode = 1'h0;
			tick(3);
			check(16'({pins.internalOe, pins.devBusOe}), 16'h0000,
				"released");
		end
		conclude();
	end
endmodule
